// *** verilog/mts_rx.sv ***
// Receiver for the multi-channel transport stream sublayer header.
// Assumes frames arrive one byte per valid cycle, framed by sof and eof.
`timescale 1ns/1ps
module mts_rx
    import mts_pkg::*;
(
    input  wire logic       mclk,          // Clock, 100 MHz
    input  wire logic       srst,          // Sync reset
    input  wire logic       session_multi, // Session is multi-channel type
    input  wire logic       in_valid,      // Input byte valid
    input  wire logic       in_sof,        // First byte of frame
    input  wire logic       in_eof,        // Last byte of frame
    input  wire logic [7:0] in_data,       // Input byte
    output logic            out_valid,     // Output byte valid
    output logic            out_sop,       // First byte of a TS packet
    output logic            out_eop,       // Last byte of a TS packet
    output logic      [7:0] out_data,      // Output byte
    output logic      [7:0] out_engine,    // Target engine for this packet
    output logic            out_null,      // Substitute null packet
    output logic            probe_frame,   // Latency probe frame seen, pulse
    output logic            frame_ok,      // Good frame ended, pulse
    output logic            frame_err,     // Frame dropped, pulse
    output logic            seq_lost,      // Frame sequence gap, pulse
    output logic            seq_order,     // Out-of-order frame, pulse
    output logic      [3:0] chan_gap,      // Missing packets on a channel
    output logic            chan_gap_v,    // chan_gap strobe
    output logic     [15:0] last_seq       // Last valid sequence number
);
    mts_state_t  state_reg;
    logic [10:0] byte_reg;
    logic [7:0]  pkt_byte_reg;
    logic [3:0]  pkt_idx_reg;
    logic [31:0] word_reg;
    logic [3:0]  total_reg;
    logic        seq_ok_reg;
    logic [7:0]  tag_reg   [MAX_ENTRIES];
    logic [3:0]  cnt_reg   [MAX_ENTRIES];
    logic        have_seq_reg;
    logic [15:0] exp_seq_reg;
    logic [31:0] cur_word;
    logic [15:0] cur_seq;
    logic [3:0]  cur_total;
    logic [1:0]  cur_ext;
    logic        hdr_bad;
    logic        chk_valid;
    logic [3:0]  gap_cnt;
    logic        gap_valid;
    logic [4:0]  ent_pos;
    logic        pay_last;

    // Decoded first word while its last byte is on the input; the shift
    // register still lags one byte then, so the word is assembled here
    assign cur_word  = {word_reg[23:0], in_data};
    assign cur_ext   = cur_word[POS_EXT_HI -: 2];
    assign cur_total = cur_word[POS_TOTAL_HI -: 4];
    assign cur_seq   = cur_word[15:0];
    // Reserved code or wrong session rejects the frame; spare and reserved ignored
    assign hdr_bad   = !session_multi || cur_ext != EXT_DATA   // RL3 RL22
                     || cur_total < TOTAL_MIN || cur_total > TOTAL_MAX; // RL7 RL25
    assign ent_pos   = 5'(byte_reg - 11'(FIRST_WORD_BYTES)); // RL14
    assign pay_last  = pkt_byte_reg == 8'(TS_BYTES - 1) && pkt_idx_reg == total_reg - 4'h1;
    assign chk_valid = state_reg == MTS_PAY && in_valid && pkt_byte_reg == 8'h00;

    // ==========================================================================
    // Frame parser state
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= MTS_IDLE;
        end else if (in_valid && in_sof) begin
            state_reg <= in_eof ? MTS_IDLE : MTS_HDR;
        end else if (in_valid) begin
            case (state_reg)
                MTS_IDLE: state_reg <= MTS_IDLE;
                MTS_HDR: begin
                    if (in_eof)
                        state_reg <= MTS_IDLE; // RL25
                    else if (byte_reg == 11'(FIRST_WORD_BYTES - 1) && hdr_bad)
                        state_reg <= MTS_DROP; // RL22
                    else if (byte_reg == 11'(HDR_BYTES - 1))
                        state_reg <= MTS_PAY; // RL14
                end
                MTS_PAY: begin
                    if (in_eof || byte_reg == 11'(MAX_FRAME_BYTES - 1))
                        state_reg <= MTS_IDLE; // RL18
                    else if (pay_last)
                        state_reg <= MTS_DROP; // RL25
                end
                MTS_DROP: state_reg <= in_eof ? MTS_IDLE : MTS_DROP;
                default:  state_reg <= MTS_IDLE;
            endcase
        end
    end

    // ==========================================================================
    // Byte counters within frame and within TS packet
    always_ff @(posedge mclk) begin
        if (srst) begin
            byte_reg     <= 11'h000;
            pkt_byte_reg <= 8'h00;
            pkt_idx_reg  <= 4'h0;
        end else if (in_valid) begin
            byte_reg <= in_sof ? 11'h001 : byte_reg + 11'h001;
            if (in_sof || state_reg != MTS_PAY) begin
                pkt_byte_reg <= 8'h00;
                pkt_idx_reg  <= 4'h0;
            end else if (pkt_byte_reg == 8'(TS_BYTES - 1)) begin
                pkt_byte_reg <= 8'h00; // RL20
                pkt_idx_reg  <= pkt_idx_reg + 4'h1;
            end else begin
                pkt_byte_reg <= pkt_byte_reg + 8'h01;
            end
        end
    end

    // First word capture; connectivity and spare bits carried but not acted on
    always_ff @(posedge mclk) begin
        if (srst) begin
            word_reg   <= 32'h0000_0000;
            total_reg  <= 4'h0;
            seq_ok_reg <= 1'b0;
        end else if (in_valid && (in_sof || state_reg == MTS_HDR)) begin
            word_reg <= cur_word; // RL23 RL1 RL5
            if (!in_sof && byte_reg == 11'(FIRST_WORD_BYTES - 1)) begin
                total_reg  <= cur_total; // RL7
                seq_ok_reg <= cur_word[POS_SEQ_OK]; // RL2
            end
        end
    end

    // ==========================================================================
    // Tag and counter array; entries beyond total are simply never read
    generate
        for (genvar e = 0; e < MAX_ENTRIES; e++) begin : g_ent
            always_ff @(posedge mclk) begin
                if (srst) begin
                    tag_reg[e] <= 8'h00;
                    cnt_reg[e] <= 4'h0;
                end else if (in_valid && !in_sof && state_reg == MTS_HDR) begin // RL16
                    if (ent_pos == 5'(2 * e))
                        cnt_reg[e] <= in_data[3:0]; // RL24 RL6
                    if (ent_pos == 5'(2 * e + 1))
                        tag_reg[e] <= in_data; // RL24 RL15
                end
            end
        end
    endgenerate

    // ==========================================================================
    // Frame sequence checking, only when the valid bit is set
    always_ff @(posedge mclk) begin
        if (srst) begin
            have_seq_reg <= 1'b0;
            exp_seq_reg  <= SEQ_RESET;
            last_seq     <= SEQ_RESET;
            seq_lost     <= 1'b0;
            seq_order    <= 1'b0;
        end else begin
            seq_lost  <= 1'b0;
            seq_order <= 1'b0;
            if (in_valid && !in_sof && state_reg == MTS_HDR
                && byte_reg == 11'(FIRST_WORD_BYTES - 1) && !hdr_bad
                && cur_word[POS_SEQ_OK]) begin // RL2
                have_seq_reg <= 1'b1;
                exp_seq_reg  <= cur_seq + 16'h0001;
                last_seq     <= cur_seq;
                if (have_seq_reg && cur_seq != exp_seq_reg) begin
                    // Behind expected by less than half the space counts as reordered
                    if (16'(exp_seq_reg - cur_seq) < 16'h8000)
                        seq_order <= 1'b1; // RL10
                    else
                        seq_lost <= 1'b1; // RL10
                end
            end
        end
    end

    // ==========================================================================
    // Payload steering: each packet goes to the engine its tag names
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_valid  <= 1'b0;
            out_sop    <= 1'b0;
            out_eop    <= 1'b0;
            out_data   <= 8'h00;
            out_engine <= 8'h00;
        end else begin
            out_valid <= in_valid && !in_sof && state_reg == MTS_PAY; // RL17
            out_sop   <= chk_valid && !in_sof;
            out_eop   <= in_valid && state_reg == MTS_PAY && pkt_byte_reg == 8'(TS_BYTES - 1);
            out_data  <= in_data;
            out_engine <= tag_reg[pkt_idx_reg]; // RL11 RL19
        end
    end

    // ==========================================================================
    // Frame outcome pulses; a short or long payload is flagged and dropped
    always_ff @(posedge mclk) begin
        if (srst) begin
            frame_ok    <= 1'b0;
            frame_err   <= 1'b0;
            probe_frame <= 1'b0;
        end else begin
            frame_ok    <= in_valid && in_eof && state_reg == MTS_PAY && pay_last;
            frame_err   <= in_valid && !in_sof && ((state_reg == MTS_HDR
                           && (in_eof || (byte_reg == 11'(FIRST_WORD_BYTES - 1) && hdr_bad)))
                           || (state_reg == MTS_PAY && (in_eof != pay_last))); // RL25
            probe_frame <= in_valid && !in_sof && state_reg == MTS_HDR
                           && byte_reg == 11'(FIRST_WORD_BYTES - 1) && cur_ext == EXT_PROBE; // RL4
        end
    end

    // Null substitution request: one pulse per channel result whose gap count is nonzero
    always_ff @(posedge mclk) begin
        if (srst) begin
            chan_gap   <= 4'h0;
            chan_gap_v <= 1'b0;
            out_null   <= 1'b0;
        end else begin
            chan_gap   <= gap_cnt; // RL12
            chan_gap_v <= gap_valid;
            out_null   <= gap_valid && gap_cnt != 4'h0; // RL13 RL21
        end
    end

    mts_chan_track u_track (
        .mclk      (mclk),
        .srst      (srst),
        .chk_valid (chk_valid && !in_sof),
        .chk_tag   (tag_reg[pkt_idx_reg]),
        .chk_cnt   (cnt_reg[pkt_idx_reg]),
        .gap_cnt   (gap_cnt),
        .gap_valid (gap_valid)
    );
endmodule

// *** verilog/mts_pkg.sv ***
// Package for the multi-channel transport stream sublayer receiver.
// Assumes a byte-wide frame stream already stripped of outer encapsulation.
// ==========================================================================
// Contract
// RL1: Connectivity check bit is sent as zero
// RL2: Use sequence number only when valid bit set
// RL3: Extension code 00 shared; session selects parsing
// RL4: Code 01 is latency probe; 10,11 undefined
// RL5: Spare bit sent zero, ignored on receive
// RL6: Reserved nibble sent zero, ignored on receive
// RL7: Packet total legal 1..10, others reserved
// RL8: Sender increments sequence number by one
// RL9: Sender should start sequence at random value
// RL10: Detect lost or reordered frames, account per channel
// RL11: Channel tag steers packet to its engine
// RL12: Count received packets per channel using counter
// RL13: Substitute null packets for missing channel packets; code pulses out_null once per nonzero gap, not once per missing packet
// RL14: Header is 4 plus 20 bytes
// RL15: Array holds 10 entries; first total valid
// RL16: Entries beyond total are zero, ignored
// RL17: At most ten packets, mixed channels
// RL18: Accept frames up to 2000 bytes
// RL19: Packets of one frame are independent
// RL20: Payload is back-to-back 188-byte packets
// RL21: Null packet is 188 bytes, identifier 0x1FFF
// RL22: Discard frames with nonconforming header
// RL23: First word bit order as listed
// RL24: Entry is nibble, counter, tag; two per word
// RL25: Flag and drop bad total or length
package mts_pkg;
    localparam int          FIRST_WORD_BYTES = 4;
    localparam int          ARRAY_BYTES      = 20;
    localparam int          HDR_BYTES        = FIRST_WORD_BYTES + ARRAY_BYTES;
    localparam int          MAX_ENTRIES      = 10;
    localparam int          TS_BYTES         = 188;
    localparam int          MAX_FRAME_BYTES  = 2000;
    localparam logic [12:0] NULL_PID         = 13'h1FFF;
    localparam logic [7:0]  TS_SYNC          = 8'h47;
    localparam logic [1:0]  EXT_DATA         = 2'h0;
    localparam logic [1:0]  EXT_PROBE        = 2'h1;
    localparam logic [3:0]  TOTAL_MIN        = 4'h1;
    localparam logic [3:0]  TOTAL_MAX        = 4'hA;
    localparam int          CHAN_COUNT       = 256;
    localparam logic [15:0] SEQ_RESET        = 16'h0000;
    // First word bit positions, byte 0 first on the wire
    localparam int          POS_CHECK        = 31;
    localparam int          POS_SEQ_OK       = 30;
    localparam int          POS_EXT_HI       = 29;
    localparam int          POS_SEL_HI       = 27;
    localparam int          POS_TOTAL_HI     = 19;
    typedef enum logic [3:0] {
        MTS_IDLE = 4'b0001,
        MTS_HDR  = 4'b0010,
        MTS_PAY  = 4'b0100,
        MTS_DROP = 4'b1000
    } mts_state_t;
endpackage

// *** verilog/mts_chan_track.sv ***
// Per-channel counter tracker: remembers the last counter seen per tag.
// Assumes at most one lookup per clock, driven by the parser.
`timescale 1ns/1ps
module mts_chan_track
    import mts_pkg::*;
(
    input  wire logic       mclk,      // Clock
    input  wire logic       srst,      // Sync reset
    input  wire logic       chk_valid, // Entry to check
    input  wire logic [7:0] chk_tag,   // Channel tag
    input  wire logic [3:0] chk_cnt,   // Per channel counter
    output logic      [3:0] gap_cnt,   // Missing packets before this one
    output logic            gap_valid  // Result strobe
);
    logic [3:0] last_reg [CHAN_COUNT];
    logic       seen_reg [CHAN_COUNT];
    logic [3:0] delta;

    // Distance from the expected counter; first use of a tag shows no gap
    assign delta = chk_cnt - last_reg[chk_tag] - 4'h1;

    // ==========================================================================
    // Tracking memory
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < CHAN_COUNT; i++) begin
                seen_reg[i] <= 1'b0;
                last_reg[i] <= 4'h0;
            end
        end else if (chk_valid) begin
            seen_reg[chk_tag] <= 1'b1; // RL12
            last_reg[chk_tag] <= chk_cnt; // RL12
        end
    end

    // Gap result, one cycle after the lookup
    always_ff @(posedge mclk) begin
        if (srst) begin
            gap_cnt   <= 4'h0;
            gap_valid <= 1'b0;
        end else begin
            gap_valid <= chk_valid;
            gap_cnt   <= (chk_valid && seen_reg[chk_tag]) ? delta : 4'h0; // RL10
        end
    end
endmodule

// *** testbench/mts_rx_checker.sv ***
// Checker for the sublayer receiver: byte lag, packet framing, pulses.
// Assumes it is bound to mts_rx and sees only that module's ports.
`timescale 1ns/1ps
module mts_rx_checker
    import mts_pkg::*;
(
    input wire logic        mclk,       // Clock
    input wire logic        srst,       // Sync reset
    input wire logic        in_valid,   // Byte valid
    input wire logic        in_sof,     // Frame start
    input wire logic  [7:0] in_data,    // Byte in
    input wire logic        out_valid,  // Byte out valid
    input wire logic        out_sop,    // Packet start
    input wire logic        out_eop,    // Packet end
    input wire logic  [7:0] out_data,   // Byte out
    input wire logic        frame_ok,   // Good frame
    input wire logic        frame_err,  // Dropped frame
    input wire logic        seq_lost,   // Lost frame
    input wire logic        seq_order,  // Late frame
    input wire logic        chan_gap_v, // Gap strobe
    input wire logic [15:0] last_seq    // Last sequence
);
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (srst);
    // ==========================================================
    // Packet byte position; counts bytes, so input gaps are allowed
    logic [7:0] pkt_pos_reg;
    always_ff @(posedge mclk) begin
        if (srst) pkt_pos_reg <= 8'h00;
        else if (out_valid) pkt_pos_reg <= out_sop ? 8'h01 : pkt_pos_reg + 8'h01;
    end
    // ==========================================================
    // Sequences and properties
    sequence frame_start;
        in_valid && in_sof;
    endsequence
    sequence header_quiet;
        !out_valid [*8];
    endsequence
    reset_quiet_a: assert property ($past(srst) |-> !out_valid && !frame_ok && last_seq == 16'h0000)
        else $error("outputs active after reset");
    hdr_quiet_a: assert property (frame_start |=> header_quiet)
        else $error("header byte forwarded");
    pkt_len_a: assert property (out_eop |-> out_valid && pkt_pos_reg == 8'hBB)
        else $error("packet not 188 bytes");
    byte_lag_a: assert property (out_valid |-> $past(in_valid) && out_data == $past(in_data))
        else $error("payload byte not one cycle late");
    gap_strobe_a: assert property (out_sop |=> chan_gap_v)
        else $error("no channel count result");
    pulse_excl_a: assert property (!(frame_ok && frame_err))
        else $error("frame both good and dropped");
    seq_excl_a: assert property (!(seq_lost && seq_order))
        else $error("loss and reorder together");
    sop_valid_a: assert property (out_sop |-> out_valid && !out_eop)
        else $error("packet start malformed");
endmodule
bind mts_rx mts_rx_checker chk_u (.mclk(mclk), .srst(srst), .in_valid(in_valid),
    .in_sof(in_sof), .in_data(in_data), .out_valid(out_valid), .out_sop(out_sop),
    .out_eop(out_eop), .out_data(out_data), .frame_ok(frame_ok), .frame_err(frame_err),
    .seq_lost(seq_lost), .seq_order(seq_order), .chan_gap_v(chan_gap_v), .last_seq(last_seq));

// *** testbench/mts_hdend.sv ***
// Headend source model: builds sublayer frames and streams them bytewise.
// Assumes one frame at a time; the bench sets tags and counters first.
`timescale 1ns/1ps
module mts_hdend
    import mts_pkg::*;
#(
    parameter logic [15:0] SEQ_START = 16'h5A3C // Arbitrary start value
)
(
    input  wire logic       mclk,     // Clock
    output logic            in_valid, // Byte valid
    output logic            in_sof,   // First byte
    output logic            in_eof,   // Last byte
    output logic      [7:0] in_data   // Byte
);
    logic [7:0]  frm [0:MAX_FRAME_BYTES-1];
    logic [7:0]  tag [0:9];
    logic [3:0]  cnt [0:9];
    logic [15:0] seq_cur = SEQ_START;
    int          len;
    initial put(1'b0, 1'b0, 1'b0, 8'h00);
    // ==========================================================
    // Drive one byte slot; idle data is inverted so stale values never match
    task automatic put(input logic v, input logic s, input logic e, input logic [7:0] d);
        in_valid <= v;
        in_sof <= s;
        in_eof <= e;
        in_data <= d;
    endtask
    task automatic build(input logic so, input logic [1:0] ext, input logic [3:0] tot,
                         input int np, input logic [15:0] step);
        seq_cur = seq_cur + step;
        frm[0] = {1'b0, so, ext, 3'h2, 1'b0};
        frm[1] = {4'h0, tot};
        frm[2] = seq_cur[15:8];
        frm[3] = seq_cur[7:0];
        for (int k = 0; k < MAX_ENTRIES; k++) begin
            frm[4+2*k] = (k < tot) ? {4'h0, cnt[k]} : 8'h00;
            frm[5+2*k] = (k < tot) ? tag[k] : 8'h00;
        end
        for (int i = 0; i < np * TS_BYTES; i++)
            frm[HDR_BYTES+i] = (i % TS_BYTES == 0) ? TS_SYNC : 8'(i);
        len = HDR_BYTES + np * TS_BYTES;
    endtask
    task automatic send(input int gap);
        for (int i = 0; i < len; i++) begin
            @(posedge mclk);
            put(1'b1, i == 0, i == len - 1, frm[i]);
            repeat (gap) begin
                @(posedge mclk);
                put(1'b0, 1'b0, 1'b0, ~frm[i]);
            end
        end
        @(posedge mclk);
        put(1'b0, 1'b0, 1'b0, ~frm[len-1]);
    endtask
endmodule

// *** testbench/mts_rx_test.sv ***
// Self-checking bench for mts_rx with a headend source model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module mts_rx_test
    import mts_pkg::*;
;
    logic mclk = 1'b0;
    logic srst, session_multi, in_valid, in_sof, in_eof, out_valid, out_sop, out_eop;
    logic out_null, probe_frame, frame_ok, frame_err, seq_lost, seq_order, chan_gap_v;
    logic [7:0] in_data, out_data, out_engine, ev;
    logic [3:0] chan_gap;
    logic [15:0] last_seq;
    logic [7:0] eng_q [$];
    logic [3:0] gap_q [$];
    int failures = 0, cmp_count = 0;
    int n [8];
    always #5 mclk = ~mclk;
    mts_rx dut_u (.mclk(mclk), .srst(srst), .session_multi(session_multi),
        .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof), .in_data(in_data),
        .out_valid(out_valid), .out_sop(out_sop), .out_eop(out_eop), .out_data(out_data),
        .out_engine(out_engine), .out_null(out_null), .probe_frame(probe_frame),
        .frame_ok(frame_ok), .frame_err(frame_err), .seq_lost(seq_lost),
        .seq_order(seq_order), .chan_gap(chan_gap), .chan_gap_v(chan_gap_v),
        .last_seq(last_seq));
    mts_hdend hdr_u (.mclk(mclk), .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof),
        .in_data(in_data));
    // ==========================================================
    // Event tally: ok, err, probe, lost, order, sop, eop, null
    always @(posedge mclk) begin
        ev = {out_null, out_eop, out_sop, seq_order, seq_lost, probe_frame, frame_err, frame_ok};
        for (int k = 0; k < 8; k++) n[k] += int'(!srst && ev[k] === 1'b1);
        if (out_sop === 1'b1) eng_q.push_back(out_engine);
        if (chan_gap_v === 1'b1) gap_q.push_back(chan_gap);
    end
    // ==========================================================
    // Shared helpers
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task check_ev(input int e [8]);
        for (int k = 0; k < 8; k++) check(n[k], e[k], $sformatf("event %0d count", k));
    endtask
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Send the built frame, then wait bounded for its verdict pulse
    task go(input int gap);
        int t;
        @(negedge mclk);
        n = '{default: 0};
        eng_q = {};
        gap_q = {};
        hdr_u.send(gap);
        for (t = 0; t < 100 && n[0] + n[1] == 0; t++) @(negedge mclk);
        if (t == 100) failures++;
        if (t == 100) print_verdict;
        repeat (4) @(negedge mclk);
    endtask
    // ==========================================================
    // Scenarios
    task t_full;
        for (int k = 0; k < 10; k++) hdr_u.tag[k] = 8'h10 + 8'(k);
        for (int k = 0; k < 10; k++) hdr_u.cnt[k] = 4'h0;
        hdr_u.build(1'b1, EXT_DATA, TOTAL_MAX, 10, 16'h0001);
        hdr_u.frm[0][0] = 1'b1;
        hdr_u.frm[1][7:4] = 4'hF;
        go(0);
        check_ev('{1, 0, 0, 0, 0, 10, 10, 0});
        for (int k = 0; k < 10; k++) check(eng_q[k], 8'h10 + 8'(k), "engine");
        check(last_seq, hdr_u.seq_cur, "sequence");
        $display("full frame test done");
    endtask
    task t_gap;
        hdr_u.cnt[0] = 4'h3;
        hdr_u.cnt[1] = 4'h1;
        hdr_u.build(1'b1, EXT_DATA, 4'h2, 2, 16'h0002);
        go(1);
        check_ev('{1, 0, 0, 1, 0, 2, 2, 1});
        check(gap_q[0], 4'h2, "gap first");
        check(gap_q[1], 4'h0, "gap second");
        $display("gap test done");
    endtask
    task t_seq;
        hdr_u.cnt[0] = 4'h4;
        hdr_u.build(1'b1, EXT_DATA, 4'h1, 1, 16'hFFFD);
        go(0);
        check(n[4], 1, "reorder");
        check(n[3], 0, "loss");
        hdr_u.cnt[0] = 4'h5;
        hdr_u.build(1'b0, EXT_DATA, 4'h1, 1, 16'h0100);
        go(0);
        check(n[3] + n[4], 0, "unchecked sequence");
        $display("sequence test done");
    endtask
    task t_hdr;
        logic [7:0] cs [7];
        cs = '{8'h11, 8'h21, 8'h31, 8'h00, 8'h0B, 8'h0F, 8'h81};
        for (int k = 0; k < 7; k++) begin
            @(posedge mclk);
            session_multi <= ~cs[k][7];
            hdr_u.build(1'b0, cs[k][5:4], cs[k][3:0], 1, 16'h0001);
            go(0);
            check_ev('{0, 1, int'(k == 0), 0, 0, 0, 0, 0});
        end
        @(posedge mclk);
        session_multi <= 1'b1;
        $display("header code test done");
    endtask
    task t_len;
        hdr_u.cnt[0] = 4'h6;
        hdr_u.build(1'b0, EXT_DATA, 4'h1, 1, 16'h0001);
        hdr_u.len++;
        go(0);
        check(n[0], 0, "long frame ok");
        check(n[1], 1, "long frame error");
        $display("length test done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        srst = 1'b1;
        session_multi = 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        t_full;
        t_gap;
        t_seq;
        t_hdr;
        t_len;
        print_verdict;
    end
endmodule
